// ===== rtl/bbes_seq.sv
// Enable and start-up sequencer of the on-chip buck-boost converter, AHB-Lite slave.
// Assumes pins asynchronous to ref_clk and a single AHB-Lite master.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bbes_consts.svh"

module bbes_seq #(
  parameter int OSC_DIV    = `BBES_OSC_DIV,
  parameter int IDLE_TICKS = `BBES_IDLE_TICKS,
  parameter int SS_TICKS   = `BBES_SS_TICKS
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        reg_master_en,
  input  wire logic        io_supply_present,
  input  wire logic        tx_fast_enable_pin,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             external_converter_control_out,
  output logic             input_high_switch,
  output logic             input_low_switch,
  output logic             output_high_switch,
  output logic             output_low_switch,
  output logic             switch_release,
  output logic             logic_reset,
  output logic             current_limit_en,
  output logic             short_circuit_en,
  output logic             softstart_done
);

  localparam int CW      = 12;
  localparam int OSC_GAP = OSC_DIV - 1; // Cycles from the cycle after a tick to the next tick

  // ==========================================================
  // Elaboration checks
  if (OSC_DIV < 2 || OSC_DIV >= (1 << CW)) begin : g_bad_div
    $error("OSC_DIV out of range");
  end
  if (IDLE_TICKS < 1 || IDLE_TICKS >= (1 << CW)) begin : g_bad_idle
    $error("IDLE_TICKS out of range");
  end
  if (SS_TICKS < 1 || SS_TICKS >= (1 << CW)) begin : g_bad_ss
    $error("SS_TICKS out of range");
  end

  // ==========================================================
  // Pin synchronisers
  logic [2:0]         pin_raw;
  logic [2:0]         s1_ff;
  logic [2:0]         s2_ff;
  logic [2:0]         s3_ff;
  logic [2:0]         pin_filt_ff;
  bbes_pkg::bbes_pins_s pins;

  assign pin_raw = {reg_master_en, io_supply_present, tx_fast_enable_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      // Three stages, change taken once stages two and three agree
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          s1_ff[gi]       <= 1'h0;
          s2_ff[gi]       <= 1'h0;
          s3_ff[gi]       <= 1'h0;
          pin_filt_ff[gi] <= 1'h0;
        end else begin
          s1_ff[gi] <= pin_raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            pin_filt_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  assign pins = bbes_pkg::bbes_pins_s'(pin_filt_ff);

  // ==========================================================
  // Registers and enable terms
  logic conv_en_ff;
  logic ext_en_ff;
  logic run_ok;
  logic ext_ok;

  assign run_ok = pins.master & pins.io & pins.tx & conv_en_ff;
  assign ext_ok = pins.master & pins.io & pins.tx & ext_en_ff;

  // ==========================================================
  // Internal oscillator tick
  logic [CW-1:0] div_ff;
  logic          osc_tick;

  assign osc_tick = (div_ff == CW'(OSC_DIV - 1));

  // Free-running divider to the switching frequency
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_ff <= '0;
    end else if (osc_tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + CW'(1);
    end
  end

  // ==========================================================
  // Sequencer
  bbes_pkg::bbes_state_e state_ff;
  bbes_pkg::bbes_state_e nxt_state;
  logic [CW-1:0]         cnt_ff;
  logic                  cnt_last_idle;
  logic                  cnt_last_ss;

  assign cnt_last_idle = osc_tick && (cnt_ff == CW'(IDLE_TICKS - 1));
  assign cnt_last_ss   = osc_tick && (cnt_ff == CW'(SS_TICKS - 1));

  // Next state
  always_comb begin
    nxt_state = state_ff;
    if (!run_ok) begin
      nxt_state = bbes_pkg::BBES_DISABLED;
    end else begin
      case (state_ff)
        bbes_pkg::BBES_DISABLED: nxt_state = bbes_pkg::BBES_IDLE;
        bbes_pkg::BBES_IDLE: begin
          if (cnt_last_idle) nxt_state = bbes_pkg::BBES_SOFTSTART;
        end
        bbes_pkg::BBES_SOFTSTART: begin
          if (cnt_last_ss) nxt_state = bbes_pkg::BBES_NORMAL;
        end
        bbes_pkg::BBES_NORMAL: nxt_state = bbes_pkg::BBES_NORMAL;
        default: nxt_state = bbes_pkg::BBES_DISABLED;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= bbes_pkg::BBES_DISABLED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Idle and ramp counter, cleared on every state change
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (nxt_state != state_ff) begin
      cnt_ff <= '0;
    end else if (osc_tick) begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  // ==========================================================
  // Power-stage outputs
  bbes_pkg::bbes_sw_s sw_ff;

  // Forced switch pattern and protection enables from the state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sw_ff            <= '{1'h0, 1'h1, 1'h1, 1'h0};
      switch_release   <= 1'h0;
      logic_reset      <= 1'h1;
      current_limit_en <= 1'h0;
      short_circuit_en <= 1'h0;
      softstart_done   <= 1'h0;
    end else begin
      sw_ff            <= '{1'h0, 1'h0, 1'h0, 1'h0};
      switch_release   <= 1'h0;
      logic_reset      <= 1'h0;
      current_limit_en <= 1'h0;
      short_circuit_en <= 1'h0;
      softstart_done   <= 1'h0;
      case (state_ff)
        bbes_pkg::BBES_DISABLED: begin
          sw_ff       <= '{1'h0, 1'h1, 1'h1, 1'h0};
          logic_reset <= 1'h1;
        end
        bbes_pkg::BBES_IDLE: switch_release <= 1'h0;
        bbes_pkg::BBES_SOFTSTART: switch_release <= 1'h1;
        bbes_pkg::BBES_NORMAL: begin
          switch_release   <= 1'h1;
          softstart_done   <= 1'h1;
          current_limit_en <= 1'h1;
          short_circuit_en <= 1'h1;
        end
        default: logic_reset <= 1'h1;
      endcase
    end
  end

  assign input_high_switch  = sw_ff.input_high_switch;
  assign input_low_switch   = sw_ff.input_low_switch;
  assign output_high_switch = sw_ff.output_high_switch;
  assign output_low_switch  = sw_ff.output_low_switch;

  // External converter control
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      external_converter_control_out <= 1'h0;
    end else begin
      external_converter_control_out <= ext_ok;
    end
  end

  // ==========================================================
  // AHB-Lite slave
  logic        take;
  logic        wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic [31:0] rd_word;
  logic [31:0] stat_word;

  assign take = hsel && htrans[1] && hready;
  assign stat_word = {21'h0, pin_filt_ff, external_converter_control_out, short_circuit_en,
                      current_limit_en, softstart_done, state_ff[3:1], run_ok};

  // Read word selected in the address phase
  always_comb begin
    rd_word = 32'h0;
    if (haddr == `BBES_CTRL_OFS) begin
      rd_word[`BBES_CTRL_CONV_BIT] = conv_en_ff;
      rd_word[`BBES_CTRL_EXT_BIT]  = ext_en_ff;
    end else if (haddr == `BBES_STAT_OFS) begin
      rd_word = stat_word;
    end
  end

  // Address phase capture and read data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_ff <= 1'h0;
      wr_addr_ff <= 32'h0;
      hrdata     <= 32'h0;
      hreadyout  <= 1'h1;
      hresp      <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
      if (hready) begin
        wr_pend_ff <= take && hwrite;
        wr_addr_ff <= haddr;
        hrdata     <= (take && !hwrite) ? rd_word : 32'h0;
      end
    end
  end

  // Control register write in the data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_en_ff <= `BBES_CONV_EN_RST;
      ext_en_ff  <= `BBES_EXT_EN_RST;
    end else if (wr_pend_ff && wr_addr_ff == `BBES_CTRL_OFS) begin
      conv_en_ff <= hwdata[`BBES_CTRL_CONV_BIT];
      ext_en_ff  <= hwdata[`BBES_CTRL_EXT_BIT];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_run_gate_off: assert property (!run_ok |=> state_ff == bbes_pkg::BBES_DISABLED)
    else $error("sequencer active without all enables");
  a_conv_reset_val: assert property ($past(rst) |-> conv_en_ff && !ext_en_ff)
    else $error("enable bits wrong after reset");
  a_ext_out_level: assert property (##1 external_converter_control_out == $past(ext_ok))
    else $error("external converter output mismatch");
  a_disable_hold: assert property (state_ff == bbes_pkg::BBES_DISABLED |=>
      logic_reset && !current_limit_en && !short_circuit_en)
    else $error("protection active while disabled");
  a_discharge_sw: assert property (state_ff == bbes_pkg::BBES_DISABLED |=>
      input_low_switch && output_high_switch && !input_high_switch && !output_low_switch)
    else $error("discharge pattern wrong");
  a_idle_quiet: assert property (state_ff == bbes_pkg::BBES_IDLE |=> !switch_release &&
      !input_low_switch && !output_high_switch && !current_limit_en && !short_circuit_en)
    else $error("switches or protection active in idle");
  a_idle_length: assert property ($past(state_ff) == bbes_pkg::BBES_IDLE &&
      state_ff == bbes_pkg::BBES_SOFTSTART |-> $past(cnt_ff) == CW'(IDLE_TICKS - 1))
    else $error("idle ended at wrong count");
  a_start_either: assert property (state_ff == bbes_pkg::BBES_DISABLED && run_ok |=>
      state_ff == bbes_pkg::BBES_IDLE)
    else $error("start-up not entered");
  a_osc_period: assert property (osc_tick |=> !osc_tick ##OSC_GAP osc_tick)
    else $error("oscillator tick period wrong");
  a_ss_done_prot: assert property ($past(state_ff) == bbes_pkg::BBES_SOFTSTART &&
      state_ff == bbes_pkg::BBES_NORMAL |=> softstart_done && current_limit_en &&
      short_circuit_en)
    else $error("protections not enabled after softstart");

  c_reach_normal: cover property (state_ff == bbes_pkg::BBES_NORMAL);
  c_abort_ss: cover property (state_ff == bbes_pkg::BBES_SOFTSTART ##1
      state_ff == bbes_pkg::BBES_DISABLED);
  c_ext_high: cover property ($rose(external_converter_control_out));

endmodule
`default_nettype wire

// ===== include/bbes_consts.svh
// Constants of the buck-boost enable sequencer: offsets, fields, resets, timing.
// Assumes a 125 MHz ref_clk and a 32-bit AHB-Lite register bus.
`ifndef BBES_CONSTS_SVH
`define BBES_CONSTS_SVH

// ==========================================================
// Register map
`define BBES_CTRL_OFS       32'h0000_0000
`define BBES_STAT_OFS       32'h0000_0004
`define BBES_CTRL_CONV_BIT  0
`define BBES_CTRL_EXT_BIT   1
`define BBES_CONV_EN_RST    1'h1
`define BBES_EXT_EN_RST     1'h0

// ==========================================================
// Timing
`define BBES_REF_KHZ        125000
`define BBES_OSC_KHZ        1500
`define BBES_OSC_DIV        (`BBES_REF_KHZ / `BBES_OSC_KHZ)
`define BBES_IDLE_NS        50000
`define BBES_IDLE_TICKS     (`BBES_IDLE_NS * `BBES_OSC_KHZ / 1000000)
`define BBES_SS_NS          500000
`define BBES_SS_TICKS       (`BBES_SS_NS * `BBES_OSC_KHZ / 1000000)

`endif

// ===== include/bbes_pkg.sv
// Types of the buck-boost enable sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package bbes_pkg;

  // ==========================================================
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    BBES_DISABLED  = 4'h1,
    BBES_IDLE      = 4'h2,
    BBES_SOFTSTART = 4'h4,
    BBES_NORMAL    = 4'h8
  } bbes_state_e;

  // Forced gate pattern for the four power switches
  typedef struct packed {
    logic input_high_switch;
    logic input_low_switch;
    logic output_high_switch;
    logic output_low_switch;
  } bbes_sw_s;

  // Filtered enable pins
  typedef struct packed {
    logic master;
    logic io;
    logic tx;
  } bbes_pins_s;

endpackage

// ===== test/bbes_host.sv
// Host side model: drives the three enable pins of the sequencer.
// Assumes requests change right after a rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none

module bbes_host (
  input  wire logic ref_clk,
  input  wire logic want_master,
  input  wire logic want_io,
  input  wire logic want_tx,
  output var  logic reg_master_en,
  output var  logic io_supply_present,
  output var  logic tx_fast_enable_pin
);
  // Pins follow the request one edge later
  always @(posedge ref_clk) begin
    reg_master_en      <= want_master;
    io_supply_present  <= want_io;
    tx_fast_enable_pin <= want_tx;
  end
endmodule

`default_nettype wire

// ===== test/buck_boost_enable_sequencer_tb.sv
// Self-checking bench of the enable sequencer: pin/bit table, start-up, abort.
// Assumes bbes_seq with shortened oscillator counts and a zero-wait slave.
`timescale 1ns/1ps
`default_nettype none
`include "bbes_consts.svh"

module buck_boost_enable_sequencer_tb;
  localparam int DIV = 4;
  localparam int IDL = 3;
  localparam int SST = 5;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        w_m = 1'b0;
  logic        w_io = 1'b0;
  logic        w_tx = 1'b0;
  logic        pin_m;
  logic        pin_io;
  logic        pin_tx;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic        hready;
  logic        hresp;
  logic        ext_out;
  logic        sw_ih;
  logic        sw_il;
  logic        sw_oh;
  logic        sw_ol;
  logic        rel_sw;
  logic        logic_reset;
  logic        cl_en;
  logic        sc_en;
  logic        ss_done;
  int          n_errors = 0;
  int          num_checks = 0;
  int          n;
  // Rows: master io tx conv ext | exp ext, exp run
  logic [6:0]  rows [8] = '{7'h7F, 7'h76, 7'h5C, 7'h3C, 7'h6C, 7'h79, 7'h70, 7'h0C};

  // ==========================================================
  // Clock and instances
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  bbes_host bbes_host_inst (.ref_clk(ref_clk), .want_master(w_m), .want_io(w_io),
    .want_tx(w_tx), .reg_master_en(pin_m), .io_supply_present(pin_io),
    .tx_fast_enable_pin(pin_tx));
  bbes_seq #(.OSC_DIV(DIV), .IDLE_TICKS(IDL), .SS_TICKS(SST)) bbes_seq_inst (
    .ref_clk(ref_clk), .rst(rst), .reg_master_en(pin_m), .io_supply_present(pin_io),
    .tx_fast_enable_pin(pin_tx), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .external_converter_control_out(ext_out),
    .input_high_switch(sw_ih), .input_low_switch(sw_il), .output_high_switch(sw_oh),
    .output_low_switch(sw_ol), .switch_release(rel_sw), .logic_reset(logic_reset),
    .current_limit_en(cl_en), .short_circuit_en(sc_en), .softstart_done(ss_done));

  // ==========================================================
  // Reporting
  task automatic fail(input string msg);
    n_errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) fail(msg);
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) fail(msg);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Bus, pin and wait helpers
  task automatic bus_wait();
    int k;
    k = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 50) begin
        fail("bus timeout");
        end_of_test();
      end
      @(posedge ref_clk);
    end
  endtask
  task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b1;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
  endtask
  task automatic ahb_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b0;
    bus_wait();
    htrans <= 2'h0;
    bus_wait();
    d = hrdata;
  endtask
  task automatic pins(input logic m, input logic io, input logic tx);
    @(posedge ref_clk);
    w_m <= m;
    w_io <= io;
    w_tx <= tx;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return logic_reset;
      1: return rel_sw;
      default: return ss_done;
    endcase
  endfunction
  task automatic wait_on(input int s, input logic v, output int c);
    c = 0;
    while (pick(s) !== v) begin
      @(posedge ref_clk);
      #1;
      c++;
      if (c > 300) begin
        fail("wait timeout");
        end_of_test();
      end
    end
  endtask
  task automatic chk_off();
    chk_bit(logic_reset, 1'b1, "logic not in reset");
    chk_bit(sw_il & sw_oh & ~sw_ih & ~sw_ol, 1'b1, "discharge pattern");
    chk_bit(cl_en | sc_en, 1'b0, "protection on while off");
  endtask
  task automatic startup();
    wait_on(0, 1'b0, n);
    chk_bit(sw_il | sw_ih | sw_ol | sw_oh | rel_sw, 1'b0, "switch on in idle");
    chk_bit(cl_en | sc_en, 1'b0, "protection on in idle");
    wait_on(1, 1'b1, n);
    chk_bit(n >= (IDL - 1) * DIV && n <= IDL * DIV + 1, 1'b1, "idle length");
    chk_bit(cl_en | sc_en, 1'b0, "protection on in softstart");
    wait_on(2, 1'b1, n);
    chk_bit(n >= (SST - 1) * DIV && n <= SST * DIV + 1, 1'b1, "softstart length");
    chk_bit(cl_en & sc_en, 1'b1, "protection off at done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk_off();
    chk_bit(ext_out, 1'b0, "ext out after reset");
    ahb_rd(`BBES_CTRL_OFS, rd);
    chk_word(rd, 32'h0000_0001, "enable bits reset");
    chk_bit(hresp, 1'b0, "bus response not okay");
    for (int i = 0; i < 8; i++) begin
      pins(rows[i][6], rows[i][5], rows[i][4]);
      ahb_wr(`BBES_CTRL_OFS, {30'h0, rows[i][2], rows[i][3]});
      repeat (12) @(posedge ref_clk);
      #1;
      chk_bit(ext_out, rows[i][1], "ext out level");
      chk_bit(logic_reset, ~rows[i][0], "run state");
    end
    ahb_wr(`BBES_CTRL_OFS, 32'h0000_0000);
    pins(1'b1, 1'b1, 1'b1);
    repeat (10) @(posedge ref_clk);
    #1;
    chk_off();
    ahb_wr(`BBES_CTRL_OFS, 32'h0000_0001);
    startup();
    ahb_rd(`BBES_STAT_OFS, rd);
    chk_word(rd, 32'h0000_0779, "status in normal");
    pins(1'b1, 1'b1, 1'b0);
    wait_on(0, 1'b1, n);
    chk_bit(n <= 8, 1'b1, "slow stop on pin");
    chk_off();
    pins(1'b1, 1'b1, 1'b1);
    startup();
    ahb_wr(`BBES_CTRL_OFS, 32'h0000_0000);
    wait_on(0, 1'b1, n);
    chk_bit(n <= 4, 1'b1, "slow stop on bit");
    chk_off();
    ahb_wr(`BBES_CTRL_OFS, 32'h0000_0001);
    wait_on(0, 1'b0, n);
    wait_on(1, 1'b1, n);
    pins(1'b1, 1'b1, 1'b0);
    wait_on(0, 1'b1, n);
    chk_bit(n <= 8, 1'b1, "slow stop in softstart");
    chk_off();
    pins(1'b1, 1'b1, 1'b1);
    startup();
    end_of_test();
  end
endmodule

`default_nettype wire
